// ===== pkg/pmseq_pkg.sv
package pmseq_pkg;
   // Clock and sequencing times
   localparam int CLK_MHZ        = 125;
   localparam int CYC_PER_MS     = CLK_MHZ * 1000;
   localparam int DEBOUNCE_MS    = 50;
   localparam int EXT_DELAY_MS   = 1;
   localparam int RESET_DELAY_MS = 20;
   localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;
   localparam int EXT_DELAY_CYC  = EXT_DELAY_MS * CYC_PER_MS;
   localparam int RESET_CYC      = RESET_DELAY_MS * CYC_PER_MS;
   localparam int CNT_W          = 24;

   // Register port of the device
   localparam int REG_AW = 2;
   localparam int REG_DW = 8;
   localparam logic [REG_AW-1:0] REG_CTRL_A = 2'h0;
   localparam logic [REG_AW-1:0] REG_CTRL_B = 2'h1;
   localparam logic [REG_AW-1:0] REG_STATUS = 2'h2;
   localparam int A_BUCK_SEQ_LSB   = 0;
   localparam int A_LINREG_SEQ_LSB = 4;
   localparam int B_FORCE_ON       = 0;
   localparam int B_RETAIN         = 1;
   localparam int B_DEEP           = 2;
   localparam logic [2:0] SEQ_HOST_BUCK   = 3'h4;
   localparam logic [2:0] SEQ_HOST_LINREG = 3'h7;
   localparam logic [REG_DW-1:0] CTRL_A_RESET = 8'h74;
   localparam logic [REG_DW-1:0] CTRL_B_RESET = 8'h01;

   // Controller registers seen by software
   localparam logic [REG_AW-1:0] HREG_CTRL = 2'h0;
   localparam logic [REG_AW-1:0] HREG_STAT = 2'h1;
   localparam int HC_KEEP   = 0;
   localparam int HC_AUTOBAT = 1;
   localparam int HC_SLEEP  = 2;
   localparam int HC_UNMASK = 3;
   localparam int HC_DEEP   = 4;
   localparam int HS_RUN    = 0;
   localparam int HS_KEY    = 1;
   localparam int HS_MEMOK  = 2;
   localparam int HS_BUSY   = 3;

   typedef enum logic [2:0] {
      PMS_OFF      = 3'h0,
      PMS_DEBOUNCE = 3'h1,
      PMS_EXT_WAIT = 3'h2,
      PMS_RAMP     = 3'h3,
      PMS_MAIN     = 3'h4,
      PMS_DEEP     = 3'h5
   } pms_state_t;

   typedef enum logic [2:0] {
      PMH_IDLE = 3'h0,
      PMH_RET  = 3'h1,
      PMH_DS   = 3'h2,
      PMH_RD   = 3'h3,
      PMH_CHK  = 3'h4,
      PMH_CLR  = 3'h5
   } pms_host_state_t;
endpackage

// ===== pkg/pmseq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmseq_if;
   logic                          push_button_in;
   logic                          keep_alive;
   logic                          buck3_pin_enable;
   logic                          keypress_out;
   logic                          processor_reset_out;
   logic                          ext_regulator_enable;
   logic [pmseq_pkg::REG_AW-1:0]  reg_addr;
   logic [pmseq_pkg::REG_DW-1:0]  reg_wdata;
   logic                          reg_wr;
   logic                          reg_rd;
   logic [pmseq_pkg::REG_DW-1:0]  reg_rdata;

   modport dev_mp (
      input  push_button_in, keep_alive, buck3_pin_enable,
      input  reg_addr, reg_wdata, reg_wr, reg_rd,
      output keypress_out, processor_reset_out, ext_regulator_enable,
      output reg_rdata
   );
   modport host_mp (
      output push_button_in, keep_alive, buck3_pin_enable,
      output reg_addr, reg_wdata, reg_wr, reg_rd,
      input  keypress_out, processor_reset_out, ext_regulator_enable,
      input  reg_rdata
   );
endinterface
`default_nettype wire

// ===== verilog/pmseq_device.sv
// How it works
// - Off: watch push button, low starts power-up
// - After debounce, keypress low, ramp rails
// - Button released without keep-alive: turn off
// - Host raises keep-alive before button release
// - Charger present: keep-alive high also starts
// - Charger auto start: keep-alive high, button free
// - Battery auto start: button tied low
// - Host option: buck code 100, linreg 111
// - External regulator first, then linreg2+buck3 after 1ms
// - Linreg2 good ramps buck1 and buck2
// - Host raises buck3 pin, then linreg1 on
// - Reset released 20ms after buck1 good
// - Force-on bit default one; cleared, pin controls
// - Light sleep: pin low drops linreg1, buck3
// - Pin high restores buck3 and linreg1
// - Host wakes on keypress by raising pin
// - Host sets retention-valid before deep sleep
// - Deep request: only buck2 and the system rail on, reset low
// - Button in deep sleep clears request, restarts
// - Host checks then clears retention-valid
// - Undervoltage restores all registers, full restart
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pmseq_device #(
   parameter int DEBOUNCE_CYC  = pmseq_pkg::DEBOUNCE_CYC,
   parameter int EXT_DELAY_CYC = pmseq_pkg::EXT_DELAY_CYC,
   parameter int RESET_CYC     = pmseq_pkg::RESET_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // Link to the processor
   pmseq_if.dev_mp   link,
   // Analog side: supplies and comparators
   input  wire logic charger_present,
   input  wire logic uvlo,
   input  wire logic linreg2_good,
   input  wire logic buck1_good,
   // Rail enables
   output logic      system_rail_en,
   output logic      buck1_en,
   output logic      buck2_en,
   output logic      buck3_en,
   output logic      linreg1_en,
   output logic      linreg2_en
);
   localparam int NS = 7;
   localparam logic [pmseq_pkg::CNT_W-1:0] DB_END =
      pmseq_pkg::CNT_W'(DEBOUNCE_CYC - 1);
   localparam logic [pmseq_pkg::CNT_W-1:0] EXT_END =
      pmseq_pkg::CNT_W'(EXT_DELAY_CYC - 1);
   localparam logic [pmseq_pkg::CNT_W-1:0] RST_END =
      pmseq_pkg::CNT_W'(RESET_CYC - 1);

   // Pin synchronisers: a rise counts once stages two and three agree high, a fall as soon as stage two falls
   logic [NS-1:0] s1_q, s2_q, s3_q, stab_q;
   wire  [NS-1:0] pins = {buck1_good, linreg2_good, uvlo, charger_present,
                          link.buck3_pin_enable, link.keep_alive,
                          link.push_button_in};
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         // Idle levels: button high, every other pin low
         s1_q   <= 7'h01;
         s2_q   <= 7'h01;
         s3_q   <= 7'h01;
         stab_q <= 7'h01;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         stab_q <= (stab_q & ~(s2_q ^ s3_q)) | (s2_q & (s2_q ~^ s3_q));
      end
   end
   wire pb_low  = ~stab_q[0];
   wire keep    = stab_q[1];
   wire pin3    = stab_q[2];
   wire chg     = stab_q[3];
   wire uv      = stab_q[4];
   wire l2_good = stab_q[5];
   wire b1_good = stab_q[6];

   // Debounce: any high level restarts the count
   logic [pmseq_pkg::CNT_W-1:0] db_cnt_q;
   logic                        pressed_q;
   always_ff @(posedge clock) begin
      if (!reset_n || !pb_low) begin
         db_cnt_q  <= '0;
         pressed_q <= 1'b0;
      end else if (db_cnt_q == DB_END) begin
         pressed_q <= 1'b1;
      end else begin
         db_cnt_q  <= db_cnt_q + 1'b1;
      end
   end

   // Registers
   logic [pmseq_pkg::CNT_W-1:0]  rst_cnt_q;
   logic [pmseq_pkg::REG_DW-1:0] ctrl_a_q;
   logic                         force_on_q, retain_q, deep_req_q;
   logic [pmseq_pkg::REG_DW-1:0] rdata_q;
   pmseq_pkg::pms_state_t        state_q, state_d;

   wire [2:0] buck_seq_code   = ctrl_a_q[pmseq_pkg::A_BUCK_SEQ_LSB +: 3];
   wire [2:0] linreg_seq_code = ctrl_a_q[pmseq_pkg::A_LINREG_SEQ_LSB +: 3];
   wire host_opt = (buck_seq_code == pmseq_pkg::SEQ_HOST_BUCK) &&
                   (linreg_seq_code == pmseq_pkg::SEQ_HOST_LINREG);
   wire wr_a  = link.reg_wr && (link.reg_addr == pmseq_pkg::REG_CTRL_A);
   wire wr_b  = link.reg_wr && (link.reg_addr == pmseq_pkg::REG_CTRL_B);
   wire wake  = (state_q == pmseq_pkg::PMS_DEEP) && pressed_q;
   wire [pmseq_pkg::REG_DW-1:0] ctrl_b =
      {5'h00, deep_req_q, retain_q, force_on_q};
   wire [pmseq_pkg::REG_DW-1:0] rd_mux =
      (link.reg_addr == pmseq_pkg::REG_CTRL_A) ? ctrl_a_q :
      (link.reg_addr == pmseq_pkg::REG_CTRL_B) ? ctrl_b :
      (link.reg_addr == pmseq_pkg::REG_STATUS) ?
         {3'h0, processor_reset_live(rst_cnt_q), 1'b0, state_q} : 8'h00;

   function automatic logic processor_reset_live(
      input logic [pmseq_pkg::CNT_W-1:0] c);
      processor_reset_live = (c == RST_END);
   endfunction

   always_ff @(posedge clock) begin
      if (!reset_n || uv) begin
         ctrl_a_q   <= pmseq_pkg::CTRL_A_RESET;
         force_on_q <= pmseq_pkg::CTRL_B_RESET[pmseq_pkg::B_FORCE_ON];
         retain_q   <= pmseq_pkg::CTRL_B_RESET[pmseq_pkg::B_RETAIN];
         deep_req_q <= pmseq_pkg::CTRL_B_RESET[pmseq_pkg::B_DEEP];
      end else begin
         if (wr_a)
            ctrl_a_q <= link.reg_wdata;
         if (wr_b) begin
            // A write in the wake cycle wins over the hardware clear
            force_on_q <= link.reg_wdata[pmseq_pkg::B_FORCE_ON];
            retain_q   <= link.reg_wdata[pmseq_pkg::B_RETAIN];
            deep_req_q <= link.reg_wdata[pmseq_pkg::B_DEEP];
         end else if (wake) begin
            deep_req_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n)
         rdata_q <= '0;
      else if (link.reg_rd)
         rdata_q <= rd_mux;
      else
         rdata_q <= '0;
   end
   assign link.reg_rdata = rdata_q;

   // Sequencer
   logic [pmseq_pkg::CNT_W-1:0] cnt_q;
   wire drop = !pb_low && !keep;
   wire pmseq_pkg::pms_state_t start_st =
      host_opt ? pmseq_pkg::PMS_EXT_WAIT : pmseq_pkg::PMS_MAIN;

   always_comb begin
      state_d = state_q;
      case (state_q)
         pmseq_pkg::PMS_OFF: begin
            if (pb_low)
               state_d = pmseq_pkg::PMS_DEBOUNCE;
            else if (chg && keep)
               state_d = start_st;
         end
         pmseq_pkg::PMS_DEBOUNCE: begin
            if (!pb_low)
               state_d = pmseq_pkg::PMS_OFF;
            else if (pressed_q)
               state_d = start_st;
         end
         pmseq_pkg::PMS_EXT_WAIT: begin
            if (drop)
               state_d = pmseq_pkg::PMS_OFF;
            else if (cnt_q == EXT_END)
               state_d = pmseq_pkg::PMS_RAMP;
         end
         pmseq_pkg::PMS_RAMP: begin
            if (drop)
               state_d = pmseq_pkg::PMS_OFF;
            else if (l2_good)
               state_d = pmseq_pkg::PMS_MAIN;
         end
         pmseq_pkg::PMS_MAIN: begin
            if (drop)
               state_d = pmseq_pkg::PMS_OFF;
            else if (deep_req_q)
               state_d = pmseq_pkg::PMS_DEEP;
         end
         pmseq_pkg::PMS_DEEP: begin
            if (wake)
               state_d = start_st;
         end
         default: state_d = pmseq_pkg::PMS_OFF;
      endcase
      if (uv)
         state_d = pmseq_pkg::PMS_OFF;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= pmseq_pkg::PMS_OFF;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      end
   end

   // Reset release timer counts only while buck1 is in range
   always_ff @(posedge clock) begin
      if (!reset_n || state_q != pmseq_pkg::PMS_MAIN || !b1_good)
         rst_cnt_q <= '0;
      else if (rst_cnt_q != RST_END)
         rst_cnt_q <= rst_cnt_q + 1'b1;
   end

   // Rail enables, all registered
   wire in_ext  = (state_q == pmseq_pkg::PMS_EXT_WAIT);
   wire in_ramp = (state_q == pmseq_pkg::PMS_RAMP);
   wire in_main = (state_q == pmseq_pkg::PMS_MAIN);
   wire in_deep = (state_q == pmseq_pkg::PMS_DEEP);
   wire stage2  = in_ramp || in_main;
   // Pin low with the mask cleared is light sleep
   wire b3_ok   = force_on_q || pin3;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         system_rail_en            <= 1'b0;
         buck1_en                  <= 1'b0;
         buck2_en                  <= 1'b0;
         buck3_en                  <= 1'b0;
         linreg1_en                <= 1'b0;
         linreg2_en                <= 1'b0;
         link.ext_regulator_enable <= 1'b0;
         link.keypress_out         <= 1'b1;
         link.processor_reset_out  <= 1'b0;
      end else begin
         system_rail_en <= (state_q != pmseq_pkg::PMS_OFF) || chg;
         link.ext_regulator_enable <= host_opt &&
                                      (in_ext || stage2);
         linreg2_en <= stage2;
         buck3_en   <= stage2 && b3_ok;
         buck1_en   <= in_main;
         buck2_en   <= in_main || in_deep;
         linreg1_en <= in_main && pin3;
         link.keypress_out <= !(pressed_q &&
                                state_q != pmseq_pkg::PMS_OFF);
         // Gated by state so reset drops with the external enable
         link.processor_reset_out <= in_main &&
                                     processor_reset_live(rst_cnt_q);
      end
   end
endmodule
`default_nettype wire

// ===== verilog/pmseq_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmseq_host (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         reset_n,
   // Link to the sequencer
   pmseq_if.host_mp                          link,
   // User button
   input  wire logic                         key_pressed,
   // Software port
   input  wire logic [pmseq_pkg::REG_AW-1:0] addr,
   input  wire logic [pmseq_pkg::REG_DW-1:0] wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [pmseq_pkg::REG_DW-1:0] rdata
);
   // Pin synchronisers
   logic [2:0] s1_q, s2_q, s3_q, stab_q;
   wire  [2:0] pins = {key_pressed, link.processor_reset_out,
                       link.keypress_out};
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s1_q   <= 3'h1;
         s2_q   <= 3'h1;
         s3_q   <= 3'h1;
         stab_q <= 3'h1;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         stab_q <= (stab_q & ~(s2_q ^ s3_q)) | (s2_q & (s2_q ~^ s3_q));
      end
   end
   wire key_low = ~stab_q[0];
   wire running = stab_q[1];
   wire key_in  = stab_q[2];

   logic keep_q, autobat_q, sleep_q, unmask_q, force_q, memok_q, run_q;
   pmseq_pkg::pms_host_state_t hst_q;
   wire wr_ctl  = wr && (addr == pmseq_pkg::HREG_CTRL);
   wire deep_go = wr_ctl && wdata[pmseq_pkg::HC_DEEP];
   wire run_up  = running && !run_q;
   wire idle    = (hst_q == pmseq_pkg::PMH_IDLE);

   // Control bits: the key's set of keep and its clear of sleep win over a software write
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         keep_q    <= 1'b0;
         autobat_q <= 1'b0;
         sleep_q   <= 1'b0;
         run_q     <= 1'b0;
      end else begin
         run_q <= running;
         if (wr_ctl) begin
            keep_q    <= wdata[pmseq_pkg::HC_KEEP] | key_low;
            autobat_q <= wdata[pmseq_pkg::HC_AUTOBAT];
            sleep_q   <= wdata[pmseq_pkg::HC_SLEEP] & ~key_low;
         end else begin
            if (key_low)
               keep_q <= 1'b1;
            if (key_low)
               sleep_q <= 1'b0;
         end
      end
   end

   // Device register traffic
   logic [pmseq_pkg::REG_AW-1:0] d_addr_q;
   logic [pmseq_pkg::REG_DW-1:0] d_wdata_q;
   logic                         d_wr_q, d_rd_q;
   wire [pmseq_pkg::REG_DW-1:0] ctl_b_base = {7'h00, force_q};

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hst_q     <= pmseq_pkg::PMH_IDLE;
         unmask_q  <= 1'b0;
         force_q   <= pmseq_pkg::CTRL_B_RESET[pmseq_pkg::B_FORCE_ON];
         memok_q   <= 1'b0;
         d_addr_q  <= '0;
         d_wdata_q <= '0;
         d_wr_q    <= 1'b0;
         d_rd_q    <= 1'b0;
      end else begin
         d_wr_q <= 1'b0;
         d_rd_q <= 1'b0;
         if (wr_ctl && wdata[pmseq_pkg::HC_UNMASK])
            unmask_q <= 1'b1;
         case (hst_q)
            pmseq_pkg::PMH_IDLE: begin
               if (run_up) begin
                  hst_q <= pmseq_pkg::PMH_RD;
               end else if (deep_go) begin
                  hst_q <= pmseq_pkg::PMH_RET;
               end else if (unmask_q) begin
                  unmask_q  <= 1'b0;
                  force_q   <= 1'b0;
                  d_addr_q  <= pmseq_pkg::REG_CTRL_B;
                  d_wdata_q <= 8'h00;
                  d_wr_q    <= 1'b1;
               end
            end
            pmseq_pkg::PMH_RET: begin
               d_addr_q  <= pmseq_pkg::REG_CTRL_B;
               d_wdata_q <= ctl_b_base |
                            (8'h01 << pmseq_pkg::B_RETAIN);
               d_wr_q    <= 1'b1;
               hst_q     <= pmseq_pkg::PMH_DS;
            end
            pmseq_pkg::PMH_DS: begin
               d_wdata_q <= ctl_b_base |
                            (8'h01 << pmseq_pkg::B_RETAIN) |
                            (8'h01 << pmseq_pkg::B_DEEP);
               d_wr_q    <= 1'b1;
               hst_q     <= pmseq_pkg::PMH_IDLE;
            end
            pmseq_pkg::PMH_RD: begin
               d_addr_q <= pmseq_pkg::REG_CTRL_B;
               d_rd_q   <= 1'b1;
               hst_q    <= pmseq_pkg::PMH_CHK;
            end
            pmseq_pkg::PMH_CHK: begin
               hst_q <= d_rd_q ? pmseq_pkg::PMH_CHK : pmseq_pkg::PMH_CLR;
               if (!d_rd_q)
                  memok_q <= link.reg_rdata[pmseq_pkg::B_RETAIN];
            end
            pmseq_pkg::PMH_CLR: begin
               d_wdata_q <= ctl_b_base;
               d_wr_q    <= 1'b1;
               hst_q     <= pmseq_pkg::PMH_IDLE;
            end
            default: hst_q <= pmseq_pkg::PMH_IDLE;
         endcase
      end
   end

   // Pins toward the device
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         link.push_button_in   <= 1'b1;
         link.keep_alive       <= 1'b0;
         link.buck3_pin_enable <= 1'b0;
         rdata                 <= '0;
      end else begin
         link.push_button_in   <= !(key_in || autobat_q);
         link.keep_alive       <= keep_q;
         link.buck3_pin_enable <= running && !sleep_q;
         if (rd && addr == pmseq_pkg::HREG_CTRL)
            rdata <= ({7'h00, keep_q} << pmseq_pkg::HC_KEEP) |
                     ({7'h00, autobat_q} << pmseq_pkg::HC_AUTOBAT) |
                     ({7'h00, sleep_q} << pmseq_pkg::HC_SLEEP);
         else if (rd && addr == pmseq_pkg::HREG_STAT)
            rdata <= {4'h0, !idle, memok_q, key_low, running};
         else
            rdata <= '0;
      end
   end
   assign link.reg_addr  = d_addr_q;
   assign link.reg_wdata = d_wdata_q;
   assign link.reg_wr    = d_wr_q;
   assign link.reg_rd    = d_rd_q;
endmodule
`default_nettype wire

// ===== bench/pmseq_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pmseq_checker #(
   parameter int DEB = 20,
   parameter int EXT = 10,
   parameter int RST = 30
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Processor side
   input  wire logic       push_button_in,
   input  wire logic       keep_alive,
   input  wire logic       buck3_pin_enable,
   // Device side
   input  wire logic       keypress_out,
   input  wire logic       processor_reset_out,
   input  wire logic       ext_regulator_enable,
   // Register port
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Run lengths saturate so a long hold never wraps back to a small count
   logic [15:0] low_q;
   logic [15:0] ext_q;
   always_ff @(posedge clock) begin
      low_q <= push_button_in ? 16'h0 : (&low_q ? low_q : low_q + 16'h1);
      ext_q <= !ext_regulator_enable ? 16'h0 : (&ext_q ? ext_q : ext_q + 16'h1);
   end
   press_len_a: assert property (
      $fell(keypress_out) |-> low_q >= DEB) else $error("keypress too early");
   rst_delay_a: assert property (
      $rose(processor_reset_out) |-> ext_q >= EXT + RST)
      else $error("reset released too early");
   rst_ext_a: assert property (
      processor_reset_out |-> ext_regulator_enable)
      else $error("reset released without external regulator");
   pin_after_rst_a: assert property (
      $rose(buck3_pin_enable) |-> processor_reset_out)
      else $error("buck3 pin raised in reset");
   drop_off_a: assert property (
      (push_button_in && !keep_alive) [*8] |-> !ext_regulator_enable)
      else $error("device stayed on without keep-alive");
   deep_reset_a: assert property (
      reg_wr && reg_addr == pmseq_pkg::REG_CTRL_B
      && reg_wdata[pmseq_pkg::B_DEEP] && processor_reset_out
      |-> ##[1:6] !processor_reset_out) else $error("deep sleep kept reset off");
   deep_retain_a: assert property (
      reg_wr && reg_addr == pmseq_pkg::REG_CTRL_B
      && reg_wdata[pmseq_pkg::B_DEEP] |-> reg_wdata[pmseq_pkg::B_RETAIN])
      else $error("deep request without retention mark");
   wake_clear_a: assert property (
      $rose(processor_reset_out) |-> ##[1:8]
      (reg_rd && reg_addr == pmseq_pkg::REG_CTRL_B) ##[1:8]
      (reg_wr && reg_addr == pmseq_pkg::REG_CTRL_B
      && !reg_wdata[pmseq_pkg::B_RETAIN])) else $error("retention not cleared");
   cover property ($fell(keypress_out));
   cover property ($rose(processor_reset_out));
   cover property (reg_wr && reg_wdata[pmseq_pkg::B_DEEP]);
endmodule
`default_nettype wire

// ===== bench/pmic_power_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmic_power_sequencer_tb;
   localparam int DEB = 20;
   localparam int EXT = 10;
   localparam int RST = 30;
   logic        clock, reset_n, key_pressed, wr, rd, charger_present, uvlo;
   logic        linreg2_good, buck1_good, sys_en, l2_en, b1_en, b2_en;
   logic        b3_en, l1_en;
   logic [1:0]  addr;
   logic [7:0]  wdata, rdata, val;
   logic [31:0] rnd;
   int          num_errors, n_tests;
   pmseq_if bus ();
   pmseq_device #(.DEBOUNCE_CYC(DEB), .EXT_DELAY_CYC(EXT), .RESET_CYC(RST))
      u_pmseq_device (.clock(clock), .reset_n(reset_n), .link(bus),
      .charger_present(charger_present), .uvlo(uvlo),
      .linreg2_good(linreg2_good), .buck1_good(buck1_good),
      .system_rail_en(sys_en), .buck1_en(b1_en), .buck2_en(b2_en),
      .buck3_en(b3_en), .linreg1_en(l1_en), .linreg2_en(l2_en));
   pmseq_host u_pmseq_host (.clock(clock), .reset_n(reset_n), .link(bus),
      .key_pressed(key_pressed), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   pmseq_checker #(.DEB(DEB), .EXT(EXT), .RST(RST)) u_pmseq_checker (
      .clock(clock), .reset_n(reset_n), .push_button_in(bus.push_button_in),
      .keep_alive(bus.keep_alive), .buck3_pin_enable(bus.buck3_pin_enable),
      .keypress_out(bus.keypress_out), .reg_addr(bus.reg_addr),
      .processor_reset_out(bus.processor_reset_out), .reg_wr(bus.reg_wr),
      .ext_regulator_enable(bus.ext_regulator_enable), .reg_rd(bus.reg_rd),
      .reg_wdata(bus.reg_wdata));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] bit8(input int b);
      return 8'h01 << b;
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic sw(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clock);
      val = rdata;
   endtask
   task automatic press(input int n);
      @(posedge clock);
      key_pressed <= 1'b1;
      cyc(n);
      key_pressed <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Comparators trail their rails by a cycle, as a real ramp would
   always @(posedge clock) begin
      linreg2_good <= l2_en;
      buck1_good   <= b1_en;
   end
   initial begin
      #40000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      {reset_n, key_pressed, wr, rd, charger_present, uvlo} = 6'h00;
      {addr, wdata} = 10'h000;
      num_errors = 0;
      n_tests = 0;
      rnd = 32'h0000000c;
      cyc(6);
      reset_n <= 1'b1;
      rnd = xs(rnd);
      press(int'(rnd[3:0]) + 3);
      cyc(50);
      chk("ext_short", bus.ext_regulator_enable, 8'h00);
      chk("key_short", bus.keypress_out, 8'h01);
      press(60);
      chk("keypress", bus.keypress_out, 8'h00);
      chk("ext_first", bus.ext_regulator_enable, 8'h01);
      chk("forced", {b3_en, l2_en, bus.buck3_pin_enable}, 8'h06);
      cyc(80);
      chk("all_on", {sys_en, l2_en, b1_en, b2_en, b3_en, l1_en}, 8'h3f);
      chk("rst_out", bus.processor_reset_out, 8'h01);
      sw(1'b0, pmseq_pkg::HREG_STAT, 8'h00);
      chk("cold_mem", val & bit8(pmseq_pkg::HS_MEMOK), 8'h00);
      sw(1'b1, pmseq_pkg::HREG_CTRL, bit8(pmseq_pkg::HC_KEEP)
         | bit8(pmseq_pkg::HC_SLEEP) | bit8(pmseq_pkg::HC_UNMASK));
      cyc(20);
      chk("sleep", {l2_en, b1_en, b2_en, b3_en, l1_en}, 8'h1c);
      sw(1'b0, pmseq_pkg::HREG_CTRL, 8'h00);
      chk("ctl_rd", val,
          bit8(pmseq_pkg::HC_KEEP) | bit8(pmseq_pkg::HC_SLEEP));
      press(40);
      cyc(20);
      chk("awake", {l2_en, b1_en, b2_en, b3_en, l1_en}, 8'h1f);
      sw(1'b1, pmseq_pkg::HREG_CTRL,
         bit8(pmseq_pkg::HC_KEEP) | bit8(pmseq_pkg::HC_DEEP));
      cyc(30);
      chk("deep", {l2_en, b1_en, b2_en, b3_en, l1_en}, 8'h04);
      chk("deep_rst", bus.processor_reset_out, 8'h00);
      press(40);
      cyc(100);
      chk("woken", {l2_en, b1_en, b2_en, b3_en, l1_en}, 8'h1f);
      sw(1'b0, pmseq_pkg::HREG_STAT, 8'h00);
      chk("mem_ok", val & bit8(pmseq_pkg::HS_MEMOK), 8'h04);
      sw(1'b1, pmseq_pkg::HREG_CTRL, 8'h00);
      cyc(20);
      chk("dropped", {sys_en, bus.ext_regulator_enable, b2_en}, 8'h00);
      charger_present <= 1'b1;
      sw(1'b1, pmseq_pkg::HREG_CTRL, bit8(pmseq_pkg::HC_KEEP));
      cyc(100);
      chk("charger", {bus.ext_regulator_enable, b1_en}, 8'h03);
      uvlo <= 1'b1;
      charger_present <= 1'b0;
      sw(1'b1, pmseq_pkg::HREG_CTRL, 8'h00);
      cyc(10);
      chk("uvlo", {bus.processor_reset_out, b2_en, b1_en}, 8'h00);
      uvlo <= 1'b0;
      cyc(40);
      chk("uvlo_off", bus.ext_regulator_enable, 8'h00);
      sw(1'b1, pmseq_pkg::HREG_CTRL, bit8(pmseq_pkg::HC_AUTOBAT));
      cyc(100);
      chk("autobat", {bus.ext_regulator_enable, b1_en}, 8'h03);
      report_and_stop();
   end
endmodule
`default_nettype wire
